// ===== ddrct_ctrl_model.sv
`timescale 1ns/1ps
module ddrct_ctrl_model
    import ddrct_pkg::*;
(
    input  wire logic            clk_i,
    output logic                 ck_o,
    output ddrct_pkg::ddrct_link_type link_o
);
    import ddrct_pkg::*;
    initial begin
        ck_o = 1'b0;
        link_o = '{1'b1, CMD_DES, 3'h0, 14'h0000};
        forever #100 ck_o = ~ck_o;
    end
    ////////////////////////////////////////
    // one command per link rise, idle lines scrambled afterwards
    task automatic issue(input logic k, input ddrct_cmd_type c, input logic [2:0] b,
                         input logic [13:0] a);
        @(negedge ck_o);
        @(posedge clk_i);
        link_o <= '{k, c, b, a};
        @(negedge ck_o);
        @(posedge clk_i);
        link_o <= '{k, CMD_DES, ~b, ~a};
    endtask : issue
endmodule : ddrct_ctrl_model

// ===== ddrct_pkg.sv
package ddrct_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // link command encoding and pin bundle
    typedef enum logic [2:0] {
        CMD_DES,
        CMD_MRS,
        CMD_ACT,
        CMD_READ,
        CMD_WRITE,
        CMD_PRE,
        CMD_REF,
        CMD_RDA
    } ddrct_cmd_type;

    typedef struct packed {
        logic          cke;
        ddrct_cmd_type cmd;
        logic [2:0]    ba;
        logic [13:0]   addr;
    } ddrct_link_type;

    typedef struct packed {
        logic dll_en;
        logic crc_en;
        logic dm_en;
        logic dbi_en;
    } ddrct_ctrl_type;

    ////////////////////////////////////////////////////////////////////////////////
    // mode register selects and field positions
    localparam logic [2:0] MR_ZERO  = 3'h0;
    localparam logic [2:0] MR_TWO   = 3'h2;
    localparam logic [2:0] MR_THREE = 3'h3;
    localparam logic [2:0] MR_FOUR  = 3'h4;
    localparam logic [2:0] MR_SEVEN = 3'h7;

    localparam int MR0_BURST_POS = 0;
    localparam int MR0_RL_POS    = 2;
    localparam int MR0_WR_POS    = 9;
    localparam int MR2_WL_POS    = 0;
    localparam int MR3_MPR_POS   = 2;
    localparam int MR4_TGL_POS   = 11;
    localparam int MR4_WPRE_POS  = 12;

    localparam logic [1:0] BURST_BL8_FIXED = 2'h0;
    localparam logic [1:0] BURST_OTF       = 2'h1;
    localparam logic [1:0] BURST_BC4_FIXED = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // counts in link clock cycles, and the grade floor
    localparam logic [7:0] WR_START_LONG  = 8'h04;
    localparam logic [7:0] WR_START_SHORT = 8'h02;
    localparam logic [7:0] BURST_NCK      = 8'h04;
    localparam logic [7:0] MR7_GAP_NCK    = 8'h05;
    localparam int         DLL_LOCK_DEF   = 512;
    localparam int         ROW_BUSY_DEF   = 16;
    localparam int         REFRESH_DEF    = 64;
    localparam int         MPR_GAP_DEF    = 8;
    localparam logic [15:0] GRADE_FLOOR   = 16'h0640;

    ////////////////////////////////////////////////////////////////////////////////
    // register map and reset values
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_STATUS = 8'h04;
    localparam logic [7:0]  OFS_GRADE  = 8'h08;
    localparam logic [7:0]  OFS_MODE   = 8'h0C;
    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [15:0] GRADE_RST  = 16'h0960;

    localparam int ST_LOCKED  = 0;
    localparam int ST_PDOWN   = 1;
    localparam int ST_CRCDM   = 2;
    localparam int ST_DBI     = 3;
    localparam int ST_RDREF   = 4;
    localparam int ST_MR7     = 5;
    localparam int ST_MPR     = 6;
    localparam int ST_GRADE   = 16;

endpackage : ddrct_pkg

// ===== ddrct_regs.sv
`timescale 1ns/1ps
module ddrct_regs
    import ddrct_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_cyc_i,
    output logic                       wb_ack_o,
    output logic      [31:0]           wb_dat_o,
    input  wire logic [31:0]           status_i,
    input  wire logic [31:0]           mode_i,
    output ddrct_pkg::ddrct_ctrl_type  ctrl_o,
    output logic      [15:0]           grade_o,
    output logic      [2:0]            flag_clr_o
);
    logic        req;
    logic        wr_go;
    logic [31:0] rdata;

    assign req   = wb_cyc_i && wb_stb_i;
    assign wr_go = req && wb_we_i && wb_ack_o;
    assign rdata = (wb_adr_i == OFS_CTRL)   ? {28'h0000000, ctrl_o} :
                   (wb_adr_i == OFS_STATUS) ? status_i :
                   (wb_adr_i == OFS_GRADE)  ? {16'h0000, grade_o} :
                   (wb_adr_i == OFS_MODE)   ? mode_i : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////////
    // one wait state, write lands on the edge that sees ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h00000000;
            ctrl_o     <= CTRL_RST;
            grade_o    <= GRADE_RST;
            flag_clr_o <= 3'h0;
        end else begin
            wb_ack_o   <= req && !wb_ack_o;
            wb_dat_o   <= rdata;
            flag_clr_o <= 3'h0;
            if (wr_go && wb_adr_i == OFS_CTRL && wb_sel_i[0]) begin
                ctrl_o <= ddrct_ctrl_type'(wb_dat_i[3:0]);
            end
            if (wr_go && wb_adr_i == OFS_GRADE) begin
                if (wb_sel_i[0]) grade_o[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) grade_o[15:8] <= wb_dat_i[15:8];
            end
            if (wr_go && wb_adr_i == OFS_STATUS && wb_sel_i[0]) begin
                flag_clr_o <= wb_dat_i[ST_MPR:ST_RDREF];
            end
        end
    end

endmodule : ddrct_regs

// ===== ddrct_sync.sv
`timescale 1ns/1ps
module ddrct_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    ////////////////////////////////////////////////////////////////////////////////
    // two flops, first one read only by the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule : ddrct_sync

// ===== ddrct_top.sv
`timescale 1ns/1ps
// Summary of operation
// - eight-beat bursts start the internal write four link cycles after write latency.
// - on-the-fly four-beat chop also starts internal write four cycles after latency.
// - mode-fixed four-beat chop starts internal write two cycles after write latency.
// - write recovery in cycles is the count programmed in mode register zero.
// - clock enable may drop while rows are busy; power-down waits for them.
// - below the 1600 grade, the 1600 grade timing values govern.
// - mode register four bit 11 selects one or two clock toggle read preamble.
// - mode register four bit 12 selects one or two clock write preamble.
// - two-clock toggle preamble drives the strobe one clock earlier.
// - bus inversion exists only for byte and sixteen-bit organisations.
module ddrct_top
    import ddrct_pkg::*;
#(
    parameter int ORG_WIDTH    = 8,
    parameter int DLL_LOCK_NCK = DLL_LOCK_DEF,
    parameter int ROW_BUSY_NCK = ROW_BUSY_DEF,
    parameter int REFRESH_NCK  = REFRESH_DEF,
    parameter int MPR_GAP_NCK  = MPR_GAP_DEF
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_cyc_i,
    output logic                       wb_ack_o,
    output logic      [31:0]           wb_dat_o,
    input  wire logic                  ck_i,
    input  wire ddrct_pkg::ddrct_link_type link_i,
    output logic                       write_start_o,
    output logic                       dqs_oe_o,
    output logic                       write_preamble_two_o,
    output logic                       powered_down_o,
    output logic                       dll_locked_o,
    output logic                       dbi_active_o,
    output logic      [4:0]            write_recovery_o
);
    import ddrct_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // parameter checks
    if (!(ORG_WIDTH == 4 || ORG_WIDTH == 8 || ORG_WIDTH == 16)) begin : g_chk_org
        $error("organisation width must be 4, 8 or 16");
    end
    if (DLL_LOCK_NCK < 2 || DLL_LOCK_NCK > 1023) begin : g_chk_dll
        $error("lock count out of range");
    end
    if (ROW_BUSY_NCK < 1 || ROW_BUSY_NCK > 255 || REFRESH_NCK < 1 || REFRESH_NCK > 255
        || MPR_GAP_NCK < 1 || MPR_GAP_NCK > 255) begin : g_chk_cnt
        $error("busy counts out of range");
    end

    localparam logic [9:0] LOCK_LAST = 10'(DLL_LOCK_NCK - 1);
    localparam logic [7:0] ROW_LOAD  = 8'(ROW_BUSY_NCK);
    localparam logic [7:0] REF_LOAD  = 8'(REFRESH_NCK);
    localparam logic [7:0] MPR_LOAD  = 8'(MPR_GAP_NCK);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    ddrct_link_type           lk;
    logic                     ck_s;
    logic                     ck_d;
    logic                     ck_rise;
    logic [$bits(ddrct_link_type):0] sync_q;
    ddrct_ctrl_type           ctrl;
    logic [15:0]              grade;
    logic [2:0]               flag_clr;
    logic [31:0]              status_word;
    logic [31:0]              mode_word;

    logic [1:0]               burst_mode;
    logic [4:0]               read_latency;
    logic [4:0]               write_latency;
    logic [4:0]               wr_cycles;
    logic                     mpr_on;
    logic                     tgl_pre2;
    logic [9:0]               lock_cnt;
    logic [7:0]               wr_cnt;
    logic [7:0]               wr_rec_cnt;
    logic [7:0]               rd_cnt;
    logic [7:0]               row_busy;
    logic [7:0]               mr7_gap;
    logic [7:0]               mpr_gap;
    logic                     pd_req;
    logic                     flag_rd_refused;
    logic                     flag_mr7;
    logic                     flag_mpr;
    logic [15:0]              eff_grade;

    logic                     is_mrs;
    logic                     is_wr;
    logic                     is_rd;
    logic                     is_row;
    logic                     is_ref;
    logic                     non_mrs;
    logic                     rd_take;
    logic                     rd_refuse;
    logic                     bc4_fixed;
    logic                     wr_fire;
    logic                     rd_end;
    logic                     busy;
    logic                     mr7_bad;
    logic                     mpr_bad;
    logic [7:0]               wr_load;
    logic [7:0]               pre_len;
    logic                     next_dqs;
    logic                     next_pd;

    ////////////////////////////////////////////////////////////////////////////////
    // link pins into the clk_i domain, link clock edge detect
    ddrct_sync #(
        .WIDTH ($bits(ddrct_link_type) + 1)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({ck_i, link_i}),
        .q_o   (sync_q)
    );

    assign ck_s    = sync_q[$bits(ddrct_link_type)];
    assign lk      = ddrct_link_type'(sync_q[$bits(ddrct_link_type)-1:0]);
    assign ck_rise = ck_s && !ck_d;

    ////////////////////////////////////////////////////////////////////////////////
    // register slave
    ddrct_regs u_regs (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .wb_adr_i   (wb_adr_i),
        .wb_dat_i   (wb_dat_i),
        .wb_we_i    (wb_we_i),
        .wb_sel_i   (wb_sel_i),
        .wb_stb_i   (wb_stb_i),
        .wb_cyc_i   (wb_cyc_i),
        .wb_ack_o   (wb_ack_o),
        .wb_dat_o   (wb_dat_o),
        .status_i   (status_word),
        .mode_i     (mode_word),
        .ctrl_o     (ctrl),
        .grade_o    (grade),
        .flag_clr_o (flag_clr)
    );

    assign status_word = {eff_grade, 9'h000, flag_mpr, flag_mr7, flag_rd_refused,
                          dbi_active_o, ctrl.crc_en && ctrl.dm_en,
                          powered_down_o, dll_locked_o};
    assign mode_word   = {13'h0000, write_preamble_two_o, tgl_pre2, burst_mode,
                          wr_cycles, read_latency, write_latency};

    ////////////////////////////////////////////////////////////////////////////////
    // command decode on link clock rising edges
    assign is_mrs    = ck_rise && lk.cmd == CMD_MRS && !powered_down_o;
    assign is_wr     = ck_rise && lk.cmd == CMD_WRITE;
    assign is_rd     = ck_rise && (lk.cmd == CMD_READ || lk.cmd == CMD_RDA);
    assign is_row    = ck_rise && (lk.cmd == CMD_ACT || lk.cmd == CMD_PRE || lk.cmd == CMD_RDA);
    assign is_ref    = ck_rise && lk.cmd == CMD_REF;
    assign non_mrs   = ck_rise && lk.cmd != CMD_DES && lk.cmd != CMD_MRS;
    assign rd_take   = is_rd && dll_locked_o;
    assign rd_refuse = is_rd && !dll_locked_o;
    assign bc4_fixed = burst_mode == BURST_BC4_FIXED;
    assign wr_load   = {3'h0, write_latency} + (bc4_fixed ? WR_START_SHORT : WR_START_LONG);
    assign wr_fire   = ck_rise && wr_cnt == 8'h01;
    assign rd_end    = ck_rise && rd_cnt == 8'h01;
    assign pre_len   = tgl_pre2 ? 8'h02 : 8'h01;
    assign next_dqs  = rd_cnt != 8'h00 && rd_cnt <= BURST_NCK + pre_len;
    assign busy      = row_busy != 8'h00 || wr_rec_cnt != 8'h00 || wr_cnt != 8'h00
                       || rd_cnt != 8'h00;
    assign next_pd   = pd_req && !busy;
    assign mr7_bad   = non_mrs && mr7_gap != 8'h00;
    assign mpr_bad   = is_mrs && lk.ba == MR_THREE && mpr_gap != 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // mode registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            burst_mode           <= BURST_BL8_FIXED;
            read_latency         <= 5'h0B;
            write_latency        <= 5'h09;
            wr_cycles            <= 5'h0A;
            mpr_on               <= 1'b0;
            tgl_pre2             <= 1'b0;
            write_preamble_two_o <= 1'b0;
        end else if (is_mrs) begin
            if (lk.ba == MR_ZERO) begin
                burst_mode   <= lk.addr[MR0_BURST_POS +: 2];
                read_latency <= lk.addr[MR0_RL_POS +: 5];
                wr_cycles    <= lk.addr[MR0_WR_POS +: 5];
            end
            if (lk.ba == MR_TWO) write_latency <= lk.addr[MR2_WL_POS +: 5];
            if (lk.ba == MR_THREE) mpr_on <= lk.addr[MR3_MPR_POS];
            if (lk.ba == MR_FOUR) begin
                tgl_pre2             <= lk.addr[MR4_TGL_POS];
                write_preamble_two_o <= lk.addr[MR4_WPRE_POS];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write start, write recovery and read strobe timers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ck_d          <= 1'b0;
            wr_cnt        <= 8'h00;
            wr_rec_cnt    <= 8'h00;
            rd_cnt        <= 8'h00;
            write_start_o <= 1'b0;
            dqs_oe_o      <= 1'b0;
        end else begin
            ck_d          <= ck_s;
            write_start_o <= wr_fire;
            dqs_oe_o      <= next_dqs;
            if (is_wr) wr_cnt <= wr_load;
            else if (ck_rise && wr_cnt != 8'h00) wr_cnt <= wr_cnt - 8'h01;
            if (wr_fire) wr_rec_cnt <= {3'h0, wr_cycles};
            else if (ck_rise && wr_rec_cnt != 8'h00) wr_rec_cnt <= wr_rec_cnt - 8'h01;
            if (rd_take) rd_cnt <= {3'h0, read_latency} + BURST_NCK;
            else if (ck_rise && rd_cnt != 8'h00) rd_cnt <= rd_cnt - 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // row activity, spacing windows, power-down
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            row_busy       <= 8'h00;
            mr7_gap        <= 8'h00;
            mpr_gap        <= 8'h00;
            pd_req         <= 1'b0;
            powered_down_o <= 1'b0;
        end else begin
            if (is_row) row_busy <= ROW_LOAD;
            else if (is_ref) row_busy <= REF_LOAD;
            else if (ck_rise && row_busy != 8'h00) row_busy <= row_busy - 8'h01;
            if (is_mrs && lk.ba == MR_SEVEN) mr7_gap <= MR7_GAP_NCK;
            else if (ck_rise && mr7_gap != 8'h00) mr7_gap <= mr7_gap - 8'h01;
            if (rd_end && mpr_on) mpr_gap <= MPR_LOAD;
            else if (ck_rise && mpr_gap != 8'h00) mpr_gap <= mpr_gap - 8'h01;
            if (ck_rise) pd_req <= !lk.cke;
            powered_down_o <= next_pd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // lock, sticky flags, grade floor, inversion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_cnt         <= 10'h000;
            dll_locked_o     <= 1'b0;
            flag_rd_refused  <= 1'b0;
            flag_mr7         <= 1'b0;
            flag_mpr         <= 1'b0;
            eff_grade        <= GRADE_FLOOR;
            dbi_active_o     <= 1'b0;
            write_recovery_o <= 5'h0A;
        end else begin
            if (!ctrl.dll_en) begin
                lock_cnt     <= 10'h000;
                dll_locked_o <= 1'b0;
            end else if (ck_rise && !dll_locked_o) begin
                lock_cnt     <= lock_cnt + 10'h001;
                dll_locked_o <= lock_cnt == LOCK_LAST;
            end
            flag_rd_refused  <= rd_refuse || (flag_rd_refused && !flag_clr[0]);
            flag_mr7         <= mr7_bad || (flag_mr7 && !flag_clr[1]);
            flag_mpr         <= mpr_bad || (flag_mpr && !flag_clr[2]);
            eff_grade        <= (grade < GRADE_FLOOR) ? GRADE_FLOOR : grade;
            dbi_active_o     <= ctrl.dbi_en && ORG_WIDTH != 4;
            write_recovery_o <= wr_cycles;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_write_taken;
        ck_rise && lk.cmd == CMD_WRITE;
    endsequence

    sequence s_mr4_taken;
        is_mrs && lk.ba == MR_FOUR;
    endsequence

    chk_write_long_start: assert property (
        s_write_taken ##0 !bc4_fixed |=> wr_cnt == {3'h0, $past(write_latency)} + 8'h04)
        else $error("long burst write start count wrong");

    chk_write_short_start: assert property (
        s_write_taken ##0 bc4_fixed |=> wr_cnt == {3'h0, $past(write_latency)} + 8'h02)
        else $error("fixed chop write start count wrong");

    chk_write_start_pulse: assert property (
        wr_fire |=> write_start_o ##1 !write_start_o)
        else $error("write start not a single pulse");

    chk_read_refused: assert property (
        rd_refuse |=> flag_rd_refused && rd_cnt == $past(rd_cnt))
        else $error("read taken without lock");

    chk_recovery_load: assert property (
        wr_fire |=> wr_rec_cnt == {3'h0, $past(wr_cycles)})
        else $error("recovery not from mode register zero");

    chk_pdown_entry: assert property (
        $rose(powered_down_o) |-> $past(pd_req) && !$past(busy))
        else $error("power-down entered while busy");

    chk_strobe_early: assert property (
        $rose(dqs_oe_o) |-> $past(rd_cnt) == BURST_NCK + $past(pre_len))
        else $error("strobe enable at wrong point");

    chk_preamble_bits: assert property (
        s_mr4_taken |=> ##1 write_preamble_two_o == $past(lk.addr[MR4_WPRE_POS], 2)
                        && tgl_pre2 == $past(lk.addr[MR4_TGL_POS], 2))
        else $error("preamble bits not taken");

    chk_mr7_window: assert property (
        is_mrs && lk.ba == MR_SEVEN |=> mr7_gap == 8'h05)
        else $error("mode register seven gap not opened");

    chk_grade_floor: assert property (
        grade >= GRADE_FLOOR |=> eff_grade == $past(grade))
        else $error("grade not passed through");

    chk_dbi_org: assert property (
        ##1 dbi_active_o == ($past(ctrl.dbi_en) && ORG_WIDTH != 4))
        else $error("inversion enabled on narrow part");

endmodule : ddrct_top

// ===== ddrct_top_test.sv
`timescale 1ns/1ps
module ddrct_top_test;
    import ddrct_pkg::*;
    logic           clk_i, rst_i, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o, ck_i;
    logic [7:0]     wb_adr_i;
    logic [31:0]    wb_dat_i, wb_dat_o, q;
    logic [3:0]     wb_sel_i;
    ddrct_link_type link_i;
    logic [4:0]     write_recovery_o;
    logic           write_start_o, powered_down_o, dll_locked_o, dbi_active_o, wpre2, dqs_oe;
    int             n_mismatch = 0, n_checks = 0, n_rise = 0, n0, i;

    ddrct_top #(.DLL_LOCK_NCK(4)) i_ddrct_top (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
        .wb_we_i, .wb_sel_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .wb_dat_o, .ck_i, .link_i,
        .write_start_o, .dqs_oe_o(dqs_oe), .write_preamble_two_o(wpre2), .powered_down_o,
        .dll_locked_o, .dbi_active_o, .write_recovery_o);
    ddrct_ctrl_model i_ddrct_ctrl_model (.clk_i, .ck_o(ck_i), .link_o(link_i));

    always @(posedge ck_i) n_rise++;
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            $display("ERROR at %0t got %h expected %h", $time, g, e);
            n_mismatch++;
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        q = wb_dat_o;
        if (i == 20) begin n_mismatch++; conclude(); end
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask : wb
    task rises(input int n);
        repeat (n) @(posedge ck_i);
        repeat (5) @(posedge clk_i);
    endtask : rises
    task cmd(input logic k, input ddrct_cmd_type c, input logic [2:0] b, input logic [13:0] a);
        i_ddrct_ctrl_model.issue(k, c, b, a);
    endtask : cmd
    task wstart(input ddrct_cmd_type c, input logic [31:0] n);
        cmd(1'b1, c, 3'h0, 14'h0000);
        n0 = n_rise;
        for (i = 0; i < 400; i++) begin
            @(posedge clk_i);
            #1;
            if ((c == CMD_WRITE ? write_start_o : dqs_oe) === 1'b1) break;
        end
        if (i == 400) begin n_mismatch++; conclude(); end
        chk(32'(n_rise - n0), n);
    endtask : wstart
    ////////////////////////////////////////
    initial begin
        {rst_i, wb_adr_i, wb_dat_i, wb_we_i, wb_stb_i, wb_cyc_i} = {1'b1, 43'h0};
        wb_sel_i = 4'hF;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(32'(write_recovery_o), 32'h0A);
        wb(1'b0, OFS_MODE, 32'h0); chk(q, 32'h0000_2969);
        wb(1'b0, 8'h10, 32'h0); chk(q, 32'h0);
        wb(1'b1, OFS_GRADE, 32'h0400);
        wb(1'b0, OFS_STATUS, 32'h0); chk(q >> 16, 32'h0640);
        $display("registers done");
        wstart(CMD_WRITE, 32'hD);
        cmd(1'b1, CMD_MRS, MR_ZERO, 14'h182E); rises(2);
        chk(32'(write_recovery_o), 32'h0C);
        wstart(CMD_WRITE, 32'hB);
        cmd(1'b1, CMD_MRS, MR_ZERO, 14'h182D); rises(2);
        wstart(CMD_WRITE, 32'hD);
        $display("write start done");
        cmd(1'b1, CMD_MRS, MR_FOUR, 14'h1800); rises(2);
        chk(32'(wpre2), 32'h1);
        wb(1'b0, OFS_MODE, 32'h0); chk(32'(q[18:15]), 32'hD);
        cmd(1'b1, CMD_MRS, MR_SEVEN, 14'h0000);
        cmd(1'b1, CMD_ACT, 3'h0, 14'h0000);
        cmd(1'b1, CMD_READ, 3'h0, 14'h0000); rises(2);
        wb(1'b1, OFS_CTRL, 32'hF); rises(6);
        chk(32'(dll_locked_o), 32'h1);
        chk(32'(dbi_active_o), 32'h1);
        wb(1'b0, OFS_STATUS, 32'h0); chk(32'(q[5:0]), 32'h3D);
        wb(1'b1, OFS_STATUS, 32'h30);
        wb(1'b0, OFS_STATUS, 32'h0); chk(32'(q[6:0]), 32'h0D);
        $display("status done");
        wstart(CMD_READ, 32'h9);
        cmd(1'b1, CMD_MRS, MR_FOUR, 14'h0000);
        cmd(1'b1, CMD_MRS, MR_THREE, 14'h0004); rises(8);
        wstart(CMD_READ, 32'hA);
        rises(6);
        cmd(1'b1, CMD_MRS, MR_THREE, 14'h0000);
        wb(1'b0, OFS_STATUS, 32'h0); chk(32'(q[6:0]), 32'h4D);
        $display("read strobe done");
        cmd(1'b1, CMD_ACT, 3'h1, 14'h0000);
        cmd(1'b0, CMD_DES, 3'h0, 14'h0000); rises(3);
        chk(32'(powered_down_o), 32'h0);
        rises(20); chk(32'(powered_down_o), 32'h1);
        cmd(1'b1, CMD_DES, 3'h0, 14'h0000); rises(1);
        chk(32'(powered_down_o), 32'h0);
        $display("power down done");
        conclude();
    end
endmodule : ddrct_top_test
